// [hw/tcb_consts.svh]
// bit positions, reset values and widths of the timer control fragment
`ifndef TCB_CONSTS_SVH
`define TCB_CONSTS_SVH
`define TCB_BIT_TRIG_EN 5
`define TCB_BIT_PWM_INV 6
`define TCB_BIT_RSVD 7
`define TCB_BIT_RUN 8
`define TCB_BIT_FREEZE 9
`define TCB_CTL_W 10
`define TCB_CTL_RESET 10'h000
`define TCB_CTL_WMASK 10'h360
`endif

// [hw/tcb_pkg.sv]
// types shared by the timer control fragment
package tcb_pkg;
  typedef struct packed {
    logic freeze;
    logic run;
    logic pwm_inv;
    logic trig_en;
  } tcb_ctl_t;
  typedef enum logic [2:0] {
    TCB_OFF = 3'h1,
    TCB_RUN = 3'h2,
    TCB_HALT = 3'h4
  } tcb_state_t;
endpackage

// [hw/tcb_ctl_reg.sv]
// control register bits: write-masked storage, reserved bit reads zero
`timescale 1ns/1ps
`include "tcb_consts.svh"
module tcb_ctl_reg (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // write port
  input wire logic wr_en,
  input wire logic [`TCB_CTL_W-1:0] wr_data,
  // register image
  output logic [`TCB_CTL_W-1:0] rd_data,
  output tcb_pkg::tcb_ctl_t ctl
);
  logic [`TCB_CTL_W-1:0] ctl_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl_reg <= `TCB_CTL_RESET;
    end else if (wr_en) begin
      ctl_reg <= wr_data & `TCB_CTL_WMASK;
    end
  end

  // reserved bit 7 is never stored so it always reads zero
  assign rd_data = ctl_reg;
  assign ctl.freeze = ctl_reg[`TCB_BIT_FREEZE];
  assign ctl.run = ctl_reg[`TCB_BIT_RUN];
  assign ctl.pwm_inv = ctl_reg[`TCB_BIT_PWM_INV];
  assign ctl.trig_en = ctl_reg[`TCB_BIT_TRIG_EN];

  property p_rsvd_zero;
    @(posedge clk) disable iff (reset) rd_data[`TCB_BIT_RSVD] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit reads one");
endmodule // tcb_ctl_reg

// [hw/tcb_timer_ctl.sv]
// timer control fragment: run, debug freeze, pwm inversion, adc trigger gating
`timescale 1ns/1ps
`include "tcb_consts.svh"
module tcb_timer_ctl (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control register access
  input wire logic ctl_wr_en,
  input wire logic [`TCB_CTL_W-1:0] ctl_wr_data,
  output logic [`TCB_CTL_W-1:0] ctl_rd_data,
  // processor debug state
  input wire logic cpu_debug_halted,
  // second counter configuration and control
  input wire logic second_capture_mode,
  output logic second_counter_count_en,
  output logic second_counter_capture_en,
  output tcb_pkg::tcb_state_t second_state,
  // first counter pwm and trigger
  input wire logic first_pwm_raw,
  input wire logic first_trigger_event,
  output logic first_pwm_out,
  output logic first_adc_trigger_out
);
  tcb_pkg::tcb_ctl_t ctl;
  tcb_pkg::tcb_state_t state_reg;
  tcb_pkg::tcb_state_t state_next;
  logic pwm_reg;
  logic trig_reg;

  tcb_ctl_reg u_ctl (
    .clk(clk),
    .reset(reset),
    .wr_en(ctl_wr_en),
    .wr_data(ctl_wr_data),
    .rd_data(ctl_rd_data),
    .ctl(ctl)
  );

  // --------------------------------------------------------------
  // second counter enable state
  // --------------------------------------------------------------
  always_comb begin
    if (!ctl.run) begin
      state_next = tcb_pkg::TCB_OFF;
    end else if (ctl.freeze && cpu_debug_halted) begin
      state_next = tcb_pkg::TCB_HALT;
    end else begin
      state_next = tcb_pkg::TCB_RUN;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= tcb_pkg::TCB_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  assign second_state = state_reg;

  // --------------------------------------------------------------
  // second counter enables decoded from state
  // --------------------------------------------------------------
  // capture logic stays armed in halt; only counting freezes
  always_comb begin
    unique case (state_reg)
      tcb_pkg::TCB_OFF: begin
        second_counter_count_en = 1'b0;
        second_counter_capture_en = 1'b0;
      end
      tcb_pkg::TCB_RUN: begin
        second_counter_count_en = !second_capture_mode;
        second_counter_capture_en = second_capture_mode;
      end
      tcb_pkg::TCB_HALT: begin
        second_counter_count_en = 1'b0;
        second_counter_capture_en = second_capture_mode;
      end
      default: begin
        // a broken one-hot code leaves the second counter idle
        second_counter_count_en = 1'b0;
        second_counter_capture_en = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------
  // first counter outputs
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwm_reg <= 1'b0;
    end else begin
      pwm_reg <= first_pwm_raw ^ ctl.pwm_inv;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trig_reg <= 1'b0;
    end else begin
      trig_reg <= first_trigger_event & ctl.trig_en;
    end
  end

  assign first_pwm_out = pwm_reg;
  assign first_adc_trigger_out = trig_reg;

  // --------------------------------------------------------------
  // checks: second counter
  // --------------------------------------------------------------
  property p_off_when_clear;
    @(posedge clk) disable iff (reset)
      !ctl.run |=> !second_counter_count_en && !second_counter_capture_en;
  endproperty
  a_off_when_clear: assert property (p_off_when_clear) else $error("run clear but active");

  property p_run_counts;
    @(posedge clk) disable iff (reset)
      ctl.run && !second_capture_mode && !(ctl.freeze && cpu_debug_halted)
      ##1 !second_capture_mode |-> second_counter_count_en;
  endproperty
  a_run_counts: assert property (p_run_counts) else $error("second counter not counting");

  property p_capture_en;
    @(posedge clk) disable iff (reset)
      ctl.run ##1 second_capture_mode |-> second_counter_capture_en;
  endproperty
  a_capture_en: assert property (p_capture_en) else $error("capture not enabled");

  property p_freeze_ignored;
    @(posedge clk) disable iff (reset)
      ctl.run && !cpu_debug_halted |=> second_state == tcb_pkg::TCB_RUN;
  endproperty
  a_freeze_ignored: assert property (p_freeze_ignored) else $error("freeze without halt");

  property p_freeze_halt;
    @(posedge clk) disable iff (reset)
      ctl.run && ctl.freeze && cpu_debug_halted |=> !second_counter_count_en;
  endproperty
  a_freeze_halt: assert property (p_freeze_halt) else $error("counted during debug halt");

  property p_free_run;
    @(posedge clk) disable iff (reset)
      !ctl.freeze |=> second_state != tcb_pkg::TCB_HALT;
  endproperty
  a_free_run: assert property (p_free_run) else $error("froze with freeze clear");

  property p_excl_en;
    @(posedge clk) disable iff (reset)
      !(second_counter_count_en && second_counter_capture_en);
  endproperty
  a_excl_en: assert property (p_excl_en) else $error("count and capture both on");

  property p_onehot;
    @(posedge clk) disable iff (reset)
      $onehot(second_state);
  endproperty
  a_onehot: assert property (p_onehot) else $error("state code broken");

  // --------------------------------------------------------------
  // checks: first counter
  // --------------------------------------------------------------
  property p_pwm;
    @(posedge clk) disable iff (reset)
      1'b1 |=> first_pwm_out == ($past(first_pwm_raw) ^ $past(ctl.pwm_inv));
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm polarity wrong");

  property p_pwm_pass;
    @(posedge clk) disable iff (reset)
      !ctl.pwm_inv |=> first_pwm_out == $past(first_pwm_raw);
  endproperty
  a_pwm_pass: assert property (p_pwm_pass) else $error("pwm altered while not inverted");

  property p_trig_off;
    @(posedge clk) disable iff (reset)
      !ctl.trig_en |=> !first_adc_trigger_out;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger leaked while disabled");

  property p_trig_on;
    @(posedge clk) disable iff (reset)
      ctl.trig_en && first_trigger_event |=> first_adc_trigger_out;
  endproperty
  a_trig_on: assert property (p_trig_on) else $error("trigger event dropped");

  property p_trig_src;
    @(posedge clk) disable iff (reset)
      !first_trigger_event |=> !first_adc_trigger_out;
  endproperty
  a_trig_src: assert property (p_trig_src) else $error("trigger without event");

  // --------------------------------------------------------------
  // checks: register image
  // --------------------------------------------------------------
  property p_write_back;
    @(posedge clk) disable iff (reset)
      ctl_wr_en |=> ctl_rd_data == ($past(ctl_wr_data) & `TCB_CTL_WMASK);
  endproperty
  a_write_back: assert property (p_write_back) else $error("control write not stored");

  property p_image_hold;
    @(posedge clk) disable iff (reset)
      !ctl_wr_en |=> $stable(ctl_rd_data);
  endproperty
  a_image_hold: assert property (p_image_hold) else $error("image changed without write");

  property p_reset_image;
    @(posedge clk) disable iff (reset)
      $fell(reset) |-> ctl_rd_data == `TCB_CTL_RESET && second_state == tcb_pkg::TCB_OFF
        && !first_pwm_out && !first_adc_trigger_out;
  endproperty
  a_reset_image: assert property (p_reset_image) else $error("state not cleared by reset");
endmodule // tcb_timer_ctl

// [verification/tcb_timer_ctl_tb.sv]
// self-checking testbench for the timer control fragment
`timescale 1ns/1ps
`include "tcb_consts.svh"
module tcb_timer_ctl_tb;
  // ----------------
  // stimulus and dut
  // ----------------
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic ctl_wr_en = 1'h0;
  logic [`TCB_CTL_W-1:0] ctl_wr_data = 10'h000;
  logic [`TCB_CTL_W-1:0] rd;
  logic halted = 1'h0;
  logic cap_mode = 1'h0;
  logic cnt_en;
  logic cap_en;
  tcb_pkg::tcb_state_t state;
  logic pwm_raw = 1'h0;
  logic trig_ev = 1'h0;
  logic pwm_out;
  logic trig_out;
  int err_total = 0;
  int checked = 0;
  tcb_timer_ctl dut (.clk(clk), .reset(reset), .ctl_wr_en(ctl_wr_en), .ctl_wr_data(ctl_wr_data),
    .ctl_rd_data(rd), .cpu_debug_halted(halted), .second_capture_mode(cap_mode),
    .second_counter_count_en(cnt_en), .second_counter_capture_en(cap_en),
    .second_state(state), .first_pwm_raw(pwm_raw), .first_trigger_event(trig_ev),
    .first_pwm_out(pwm_out), .first_adc_trigger_out(trig_out));
  initial begin
    forever #2 clk = ~clk;
  end
  // ------------
  // shared tasks
  // ------------
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] d);
    @(negedge clk);
    ctl_wr_en = 1'h1;
    ctl_wr_data = d;
    @(negedge clk);
    ctl_wr_en = 1'h0;
  endtask
  // two cycles let the state register settle after any input change
  task automatic st(input tcb_pkg::tcb_state_t s, input logic c, input logic p);
    repeat (2) @(negedge clk);
    chk(10'(state), 10'(s), "state");
    chk(10'(cnt_en), 10'(c), "count enable");
    chk(10'(cap_en), 10'(p), "capture enable");
  endtask
  task automatic complete_run;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ---------
  // scenarios
  // ---------
  task automatic t_second;
    chk(rd, `TCB_CTL_RESET, "reset image");
    st(tcb_pkg::TCB_OFF, 1'h0, 1'h0);
    wr(10'h3FF);
    chk(rd, `TCB_CTL_WMASK, "masked image");
    st(tcb_pkg::TCB_RUN, 1'h1, 1'h0);
    cap_mode = 1'h1;
    st(tcb_pkg::TCB_RUN, 1'h0, 1'h1);
    cap_mode = 1'h0;
    halted = 1'h1;
    st(tcb_pkg::TCB_HALT, 1'h0, 1'h0);
    cap_mode = 1'h1;
    st(tcb_pkg::TCB_HALT, 1'h0, 1'h1);
    cap_mode = 1'h0;
    halted = 1'h0;
    st(tcb_pkg::TCB_RUN, 1'h1, 1'h0);
    wr(10'h160);
    halted = 1'h1;
    st(tcb_pkg::TCB_RUN, 1'h1, 1'h0);
    wr(10'h200);
    cap_mode = 1'h1;
    st(tcb_pkg::TCB_OFF, 1'h0, 1'h0);
    chk(rd, 10'h200, "freeze only image");
    cap_mode = 1'h0;
    halted = 1'h0;
  endtask
  task automatic t_first;
    for (int i = 0; i < 2; i++) begin
      wr(i[0] ? 10'h060 : 10'h000);
      for (int r = 0; r < 2; r++) begin
        pwm_raw = r[0];
        trig_ev = 1'h1;
        @(negedge clk);
        trig_ev = 1'h0;
        chk(10'(pwm_out), 10'(r[0] ^ i[0]), "pwm out");
        chk(10'(trig_out), 10'(i[0]), "trigger out");
        @(negedge clk);
        chk(10'(trig_out), 10'h000, "trigger pulse end");
      end
    end
  endtask
  task automatic t_reset;
    pwm_raw = 1'h0;
    wr(10'h260);
    wr(rd | 10'h100);
    chk(rd, 10'h360, "modified image");
    chk(10'(pwm_out), 10'h001, "pwm inverted");
    reset = 1'h1;
    @(negedge clk);
    chk(rd, `TCB_CTL_RESET, "mid-run reset image");
    chk(10'(state), 10'(tcb_pkg::TCB_OFF), "mid-run reset state");
    chk(10'(pwm_out), 10'h000, "mid-run reset pwm");
    reset = 1'h0;
    pwm_raw = 1'h1;
    st(tcb_pkg::TCB_OFF, 1'h0, 1'h0);
    chk(10'(pwm_out), 10'h001, "pwm not inverted");
  endtask
  initial begin
    repeat (6) @(negedge clk);
    reset = 1'h0;
    t_second();
    t_first();
    t_reset();
    complete_run();
  end
  initial begin
    #20000;
    err_total++;
    complete_run();
  end
endmodule // tcb_timer_ctl_tb
